// [rtl/bus_txn_pkg.sv]
// Constants and types shared by the bus transaction unit
package bus_txn_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int ADDR_W = 30;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int CNT_W = 2;
  localparam int KIND_W = 3;

  // ****************************************
  // Transfer sizes requested by the core
  // ****************************************
  localparam logic [1:0] SIZE_SINGLE = 2'h0;
  localparam logic [1:0] SIZE_DOUBLE = 2'h1;
  localparam logic [1:0] SIZE_QUAD = 2'h2;

  // Remaining-word count loaded at the start of a transfer
  localparam logic [1:0] CNT_SINGLE = 2'h0;
  localparam logic [1:0] CNT_DOUBLE = 2'h1;
  localparam logic [1:0] CNT_QUAD = 2'h3;
  localparam logic [1:0] CNT_LAST = 2'h0;

  // Word address field that steps through a block
  localparam int WORD_LSB = 0;
  localparam int WORD_MSB = 1;

  // Fault kind bit positions
  localparam int KIND_WRITE = 0;
  localparam int KIND_TEXT = 1;
  localparam int KIND_LOCK = 2;

  // ****************************************
  // Reset values and the all-lanes byte enable
  // ****************************************
  localparam logic RST_DATA_OE_N = 1'h1;
  localparam logic RST_RD = 1'h1;
  localparam logic [3:0] RST_BE = 4'h0;
  localparam logic [1:0] RST_CNT = 2'h0;
  localparam logic [3:0] BE_ALL = 4'hF;

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_OWN,
    ST_XFER,
    ST_WAIT,
    ST_RETRY,
    ST_DEAD
  } state_type;

endpackage : bus_txn_pkg

// [rtl/pin_sync.sv]
// Two-stage synchroniser for asynchronous input pins
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sync_type;

  sync_type r_ff;
  sync_type nxt_r;

  initial
  begin
    if (WIDTH < 1)
    begin
      $error("pin_sync: WIDTH must be at least 1");
    end
  end

  // The first stage feeds only the second stage
  always_comb
  begin
    nxt_r.s1 = pin_in;
    nxt_r.s2 = r_ff.s1;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      r_ff <= '0;
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end

  assign pin_out = r_ff.s2;

endmodule : pin_sync
`default_nettype wire

// [rtl/processor_bus_transaction_unit.sv]
// Bus-master transaction sequencer for the processor system bus
//
// Notes on behaviour
// RULE1: Each transfer opens with a start strobe; the slave acknowledges it.
// RULE2: A failed transfer ends by hard reset, or bus error with acknowledge.
// RULE3: An interlocked transfer ends when lock drops after an acknowledge.
// RULE4: A multi-word transfer ends on the acknowledge seen with word count zero.
// RULE5: Sub-word accesses are single-word accesses with only addressed byte lanes.
// RULE6: Text reads are always two words; data reads one, two or four.
// RULE7: After a read, an owner with nothing queued loops back instead of releasing.
// RULE8: In loopback all outputs hold and the last read word is driven back.
// RULE9: Writes are one, two or four words.
// RULE10: Between writes with nothing pending the outputs keep their last values.
// RULE11: Lock stays asserted from the read portion through the write portion.
// RULE12: Grant lost during an interlocked sequence delays handover by one cycle.
// RULE13: After the locked write acknowledge, lock holds one extra dead cycle.
// RULE14: Each block word steps the word address up and the count down.
// RULE15: A retried block resumes from the aborted word.
// RULE16: Retry aborts the transfer and masks acknowledge while it stays asserted.
// RULE17: After retry drops, the transfer reruns once the bus is owned again.
// RULE18: Bus error with acknowledge raises a fault typed by the transaction kind.
// RULE19: Hard reset resets the unit and abandons any bus cycle.
// RULE20: Termination priority is hard reset, then retry, then acknowledge.
// RULE21: Without grant, ownership holds until last acknowledge and lock release.
// RULE22: Ownership acknowledge is high while owning, dropped when ownership ends.
// RULE23: The word count loads words minus one and holds until each acknowledge.
// RULE24: The slave acknowledges each started word exactly once for one cycle.
`timescale 1ns/1ns
`default_nettype none
module processor_bus_transaction_unit #(
  parameter int ADDR_W = bus_txn_pkg::ADDR_W,
  parameter int DATA_W = bus_txn_pkg::DATA_W
) (
  input wire logic mclk,
  input wire logic rst,
  // Core request side
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic req_text,
  input wire logic req_lock,
  input wire logic [1:0] req_size,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [3:0] req_be,
  input wire logic [DATA_W-1:0] wdata,
  output logic wdata_take,
  output logic rsp_valid,
  output logic rsp_last,
  output logic [DATA_W-1:0] rsp_data,
  output logic fault,
  output logic [2:0] fault_kind,
  output logic core_reset,
  // Bus pins
  output logic bus_request,
  input wire logic arbiter_grant,
  output logic bus_ownership_ack,
  output logic start,
  output logic read_not_write,
  output logic text_not_data,
  output logic lock,
  output logic [1:0] remaining_word_count,
  output logic [ADDR_W-1:0] address,
  output logic [3:0] byte_lane_enable,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe_n,
  input wire logic transfer_acknowledge,
  input wire logic bus_error_input,
  input wire logic retry,
  input wire logic hard_system_reset
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  initial
  begin
    if (ADDR_W < 2 || DATA_W < 8)
    begin
      $error("processor_bus_transaction_unit: ADDR_W or DATA_W too small");
    end
  end

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    bus_txn_pkg::state_type st;
    logic own;
    logic pend;
    logic breq;
    logic start;
    logic rd;
    logic text;
    logic lock;
    logic [1:0] cnt;
    logic [ADDR_W-1:0] addr;
    logic [3:0] be;
    logic [DATA_W-1:0] dout;
    logic doe_n;
    logic retried;
    logic rsp_valid;
    logic rsp_last;
    logic [DATA_W-1:0] rdata;
    logic fault;
    logic [2:0] kind;
    logic core_rst;
  } unit_type;

  localparam int SYNC_W = DATA_W + 5;

  unit_type r_ff;
  unit_type nxt_r;
  logic [SYNC_W-1:0] sync_out;
  logic grant_s;
  logic ack_s;
  logic bus_error_input_s;
  logic retry_s;
  logic hrst_s;
  logic [DATA_W-1:0] din_s;
  logic accept;
  logic go_x;

  // Words minus one for a requested size; text is forced to two words
  function automatic logic [1:0] words_m1(input logic [1:0] size, input logic txt);
    logic [1:0] w;
    w = bus_txn_pkg::CNT_SINGLE;
    if (txt || size == bus_txn_pkg::SIZE_DOUBLE)
    begin
      w = bus_txn_pkg::CNT_DOUBLE; // see RULE6
    end
    else if (size == bus_txn_pkg::SIZE_QUAD)
    begin
      w = bus_txn_pkg::CNT_QUAD;
    end
    return w; // see RULE9
  endfunction : words_m1

  // ****************************************
  // Input synchronisation
  // ****************************************
  // Data rides the same two stages as acknowledge so they stay aligned
  pin_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .pin_in({data_in, arbiter_grant, transfer_acknowledge, bus_error_input, retry,
             hard_system_reset}),
    .pin_out(sync_out)
  );

  assign din_s = sync_out[SYNC_W-1:5];
  assign grant_s = sync_out[4];
  assign ack_s = sync_out[3];
  assign bus_error_input_s = sync_out[2];
  assign retry_s = sync_out[1];
  assign hrst_s = sync_out[0];

  // ****************************************
  // Core handshake
  // ****************************************
  // A request is taken only when the bus is quiet or merely owned
  assign req_ready = !hrst_s
                     && ((r_ff.st == bus_txn_pkg::ST_IDLE && !r_ff.pend)
                         || r_ff.st == bus_txn_pkg::ST_OWN);
  assign accept = req_valid && req_ready;

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    nxt_r = r_ff;
    go_x = 1'b0;
    wdata_take = 1'b0;
    nxt_r.start = 1'b0;
    nxt_r.rsp_valid = 1'b0;
    nxt_r.rsp_last = 1'b0;
    nxt_r.fault = 1'b0;
    nxt_r.core_rst = 1'b0;
    if (hrst_s)
    begin
      // Hard reset outranks every other termination
      nxt_r.st = bus_txn_pkg::ST_IDLE; // see RULE19
      nxt_r.own = 1'b0; // see RULE20
      nxt_r.pend = 1'b0;
      nxt_r.breq = 1'b0;
      nxt_r.lock = 1'b0;
      nxt_r.retried = 1'b0;
      nxt_r.doe_n = bus_txn_pkg::RST_DATA_OE_N;
      nxt_r.core_rst = 1'b1; // see RULE2
    end
    else
    begin
      if (accept)
      begin
        nxt_r.rd = !req_write;
        nxt_r.text = req_text && !req_write;
        nxt_r.lock = r_ff.lock || req_lock; // see RULE11
        nxt_r.cnt = words_m1(req_size, req_text && !req_write); // see RULE23
        nxt_r.addr = req_addr;
        // Byte lanes narrow only single-word accesses
        nxt_r.be = (words_m1(req_size, req_text && !req_write) == bus_txn_pkg::CNT_SINGLE)
                   ? req_be : bus_txn_pkg::BE_ALL; // see RULE5
        nxt_r.retried = 1'b0;
      end
      case (r_ff.st)
        bus_txn_pkg::ST_IDLE:
        begin
          nxt_r.doe_n = bus_txn_pkg::RST_DATA_OE_N;
          if (accept)
          begin
            nxt_r.pend = 1'b1;
            nxt_r.breq = 1'b1;
          end
          else if (r_ff.pend && grant_s)
          begin
            nxt_r.own = 1'b1; // see RULE22
            go_x = 1'b1;
          end
        end
        bus_txn_pkg::ST_OWN:
        begin
          if (accept)
          begin
            go_x = 1'b1;
          end
          else if (!grant_s && !r_ff.lock) // see RULE21
          begin
            // Ownership ends here and the acknowledge drops with it
            nxt_r.own = 1'b0; // see RULE22
            nxt_r.st = bus_txn_pkg::ST_IDLE;
            nxt_r.breq = 1'b0;
            nxt_r.doe_n = bus_txn_pkg::RST_DATA_OE_N;
          end
        end
        bus_txn_pkg::ST_XFER:
        begin
          nxt_r.st = bus_txn_pkg::ST_WAIT;
        end
        bus_txn_pkg::ST_WAIT:
        begin
          // Grant loss is ignored until the transfer has fully ended
          if (retry_s)
          begin
            // Acknowledge is masked while retry stands
            nxt_r.st = bus_txn_pkg::ST_RETRY; // see RULE16
            nxt_r.retried = 1'b1; // see RULE20
          end
          else if (ack_s && bus_error_input_s)
          begin
            nxt_r.fault = 1'b1; // see RULE18
            nxt_r.kind[bus_txn_pkg::KIND_WRITE] = !r_ff.rd;
            nxt_r.kind[bus_txn_pkg::KIND_TEXT] = r_ff.text;
            nxt_r.kind[bus_txn_pkg::KIND_LOCK] = r_ff.lock;
            nxt_r.lock = 1'b0; // see RULE2
            nxt_r.cnt = bus_txn_pkg::CNT_LAST;
            nxt_r.st = bus_txn_pkg::ST_OWN;
          end
          else if (ack_s)
          begin
            nxt_r.rsp_valid = r_ff.rd; // see RULE1
            nxt_r.rsp_last = (r_ff.cnt == bus_txn_pkg::CNT_LAST);
            if (r_ff.rd)
            begin
              nxt_r.rdata = din_s;
            end
            if (r_ff.cnt == bus_txn_pkg::CNT_LAST)
            begin
              // Last word: the transfer is over
              nxt_r.st = bus_txn_pkg::ST_OWN; // see RULE4
              if (r_ff.rd)
              begin
                // Loop the read word back instead of floating the bus
                nxt_r.dout = din_s; // see RULE7
                nxt_r.doe_n = 1'b0; // see RULE8
              end
              else if (r_ff.lock)
              begin
                nxt_r.st = bus_txn_pkg::ST_DEAD; // see RULE13
              end
            end
            else
            begin
              nxt_r.cnt = r_ff.cnt - 2'h1; // see RULE14
              nxt_r.addr[bus_txn_pkg::WORD_MSB:bus_txn_pkg::WORD_LSB] =
                r_ff.addr[bus_txn_pkg::WORD_MSB:bus_txn_pkg::WORD_LSB] + 2'h1;
              go_x = 1'b1;
            end
          end
        end
        bus_txn_pkg::ST_RETRY:
        begin
          // Outputs hold; word position is kept so a block resumes in place
          if (!retry_s)
          begin
            if (r_ff.own && grant_s)
            begin
              go_x = 1'b1; // see RULE15
            end
            else
            begin
              // Rerun waits for ownership to be won again
              nxt_r.own = 1'b0; // see RULE17
              nxt_r.st = bus_txn_pkg::ST_IDLE;
              nxt_r.pend = 1'b1;
              nxt_r.breq = 1'b1;
              nxt_r.doe_n = bus_txn_pkg::RST_DATA_OE_N;
            end
          end
        end
        bus_txn_pkg::ST_DEAD:
        begin
          // Lock released one cycle late, which also delays any handover
          nxt_r.lock = 1'b0; // see RULE3
          nxt_r.st = bus_txn_pkg::ST_OWN; // see RULE12
        end
        default:
        begin
          nxt_r.st = bus_txn_pkg::ST_IDLE;
        end
      endcase
      if (go_x)
      begin
        nxt_r.st = bus_txn_pkg::ST_XFER;
        nxt_r.start = 1'b1; // see RULE1
        nxt_r.pend = 1'b0;
        nxt_r.retried = 1'b0;
        nxt_r.doe_n = nxt_r.rd;
        // A reissued word reuses its held data instead of taking a new one
        if (!nxt_r.rd && !r_ff.retried)
        begin
          nxt_r.dout = wdata;
          wdata_take = 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      r_ff <= '{st: bus_txn_pkg::ST_IDLE,
                rd: bus_txn_pkg::RST_RD,
                be: bus_txn_pkg::RST_BE,
                cnt: bus_txn_pkg::RST_CNT,
                doe_n: bus_txn_pkg::RST_DATA_OE_N,
                default: '0};
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Bus outputs come straight from registers and change only when the next-state logic reloads them
  assign bus_request = r_ff.breq;
  assign bus_ownership_ack = r_ff.own;
  assign start = r_ff.start;
  assign read_not_write = r_ff.rd;
  assign text_not_data = r_ff.text;
  assign lock = r_ff.lock;
  assign remaining_word_count = r_ff.cnt;
  assign address = r_ff.addr;
  assign byte_lane_enable = r_ff.be; // see RULE10
  assign data_out = r_ff.dout;
  assign data_oe_n = r_ff.doe_n;
  assign rsp_valid = r_ff.rsp_valid;
  assign rsp_last = r_ff.rsp_last;
  assign rsp_data = r_ff.rdata;
  assign fault = r_ff.fault;
  assign fault_kind = r_ff.kind;
  assign core_reset = r_ff.core_rst;

endmodule : processor_bus_transaction_unit
`default_nettype wire

// [dv/ptu_checker.sv]
// Pin-level assertions for the bus transaction unit
`timescale 1ns/1ns
`default_nettype none
module ptu_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic start,
  input wire logic bus_ownership_ack,
  input wire logic lock,
  input wire logic read_not_write,
  input wire logic text_not_data,
  input wire logic [1:0] remaining_word_count,
  input wire logic [3:0] byte_lane_enable,
  input wire logic [31:0] data_out,
  input wire logic data_oe_n,
  input wire logic [31:0] rsp_data,
  input wire logic rsp_valid,
  input wire logic rsp_last,
  input wire logic fault,
  input wire logic core_reset,
  input wire logic transfer_acknowledge,
  input wire logic bus_error_input,
  input wire logic retry,
  input wire logic hard_system_reset
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ****************************************
  // Steps of the locked write ending
  // ****************************************
  sequence locked_write_ack;
    lock && !read_not_write && transfer_acknowledge && !bus_error_input && !retry &&
      remaining_word_count == 2'h0;
  endsequence
  sequence dead_then_free;
    lock [*4] ##1 !lock;
  endsequence
  AST_START_PULSE: assert property (start |=> !start)
    else $error("start wider than one cycle");
  AST_START_OWNED: assert property (start |-> bus_ownership_ack)
    else $error("start without ownership");
  AST_LOCK_OWNED: assert property (lock |-> bus_ownership_ack)
    else $error("lock held without ownership");
  AST_BLOCK_LANES: assert property (start && remaining_word_count != 2'h0 |->
    byte_lane_enable == 4'hF)
    else $error("block word with partial lanes");
  AST_TEXT_DOUBLE: assert property (start && text_not_data |->
    read_not_write && remaining_word_count <= 2'h1)
    else $error("text fetch not a double read");
  AST_LAST_COUNT: assert property (rsp_valid && rsp_last |-> remaining_word_count == 2'h0)
    else $error("last word with nonzero count");
  AST_LOOPBACK: assert property ($fell(data_oe_n) && read_not_write |->
    rsp_valid && data_out == rsp_data)
    else $error("loopback word differs from read word");
  AST_RETRY_MASK: assert property (retry [*5] |-> !rsp_valid)
    else $error("acknowledge taken under retry");
  AST_BUS_ERROR_INPUT_FAULT: assert property (bus_error_input && transfer_acknowledge && !retry &&
    !hard_system_reset |-> ##[3:4] fault)
    else $error("bus error raised no fault");
  AST_HARD_SYSTEM_RESET_ABORT: assert property (hard_system_reset [*4] |->
    core_reset && !start && !lock && !bus_ownership_ack && data_oe_n)
    else $error("hard reset left cycle running");
  AST_LOCK_DEAD: assert property (locked_write_ack |-> dead_then_free)
    else $error("locked write dead cycle wrong");
endmodule : ptu_checker
`default_nettype wire

// [dv/bus_slave_model.sv]
// Arbiter and addressed slave facing the bus transaction unit
`timescale 1ns/1ns
`default_nettype none
module bus_slave_model (
  input wire logic mclk,
  input wire logic bus_request,
  input wire logic start,
  input wire logic [29:0] address,
  input wire logic [1:0] remaining_word_count,
  input wire logic [3:0] byte_lane_enable,
  input wire logic [31:0] data_out,
  input wire logic hard_system_reset,
  output logic arbiter_grant,
  output logic transfer_acknowledge,
  output logic bus_error_input,
  output logic retry,
  output logic [31:0] data_in
);
  int delay = 1;
  int starts = 0;
  bit grant_en = 1'b1;
  bit bus_error_input_arm = 1'b0;
  bit retry_arm = 1'b0;
  logic [29:0] log_addr[$];
  logic [1:0] log_cnt[$];
  logic [3:0] log_be[$];
  logic [31:0] log_data[$];
  always @(negedge mclk)
    arbiter_grant <= bus_request && grant_en;
  initial
  begin
    arbiter_grant = 1'b0;
    transfer_acknowledge = 1'b0;
    bus_error_input = 1'b0;
    retry = 1'b0;
    data_in = 32'h0;
    forever
    begin
      @(posedge mclk);
      if (start === 1'b1)
      begin
        starts++;
        repeat (delay) @(negedge mclk);
        if (retry_arm && remaining_word_count == 2'h0)
        begin
          // A stray acknowledge inside the retry window must be ignored
          retry_arm = 1'b0;
          retry <= 1'b1;
          repeat (2) @(negedge mclk);
          transfer_acknowledge <= 1'b1;
          @(negedge mclk);
          transfer_acknowledge <= 1'b0;
          repeat (3) @(negedge mclk);
          retry <= 1'b0;
        end
        else if (!hard_system_reset)
        begin
          transfer_acknowledge <= 1'b1;
          bus_error_input <= bus_error_input_arm;
          data_in <= {2'h0, address} ^ 32'h5A00_0000;
          log_addr.push_back(address);
          log_cnt.push_back(remaining_word_count);
          log_be.push_back(byte_lane_enable);
          log_data.push_back(data_out);
          @(negedge mclk);
          transfer_acknowledge <= 1'b0;
          bus_error_input <= 1'b0;
          bus_error_input_arm = 1'b0;
          // Released data lines must not keep showing the word
          data_in <= ~data_in;
        end
      end
    end
  end
endmodule : bus_slave_model
`default_nettype wire

// [dv/processor_bus_transaction_unit_bench.sv]
// Self-checking bench for the bus transaction unit
`timescale 1ns/1ns
`default_nettype none
module processor_bus_transaction_unit_bench;
  logic mclk, rst, req_valid, req_ready, req_write, req_text, req_lock, wdata_take;
  logic rsp_valid, rsp_last, fault, core_reset, bus_request, arbiter_grant;
  logic bus_ownership_ack, start, read_not_write, text_not_data, lock, data_oe_n;
  logic transfer_acknowledge, bus_error_input, retry, hard_system_reset;
  logic [1:0] req_size, remaining_word_count;
  logic [2:0] fault_kind;
  logic [3:0] req_be, byte_lane_enable;
  logic [29:0] req_addr, address;
  logic [31:0] wdata, rsp_data, data_in, data_out;
  int err_total = 0;
  int checks = 0;
  int cycles = 0;
  int wnum = 0;
  processor_bus_transaction_unit dut_u (.mclk(mclk), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_text(req_text), .req_lock(req_lock),
    .req_size(req_size), .req_addr(req_addr), .req_be(req_be), .wdata(wdata),
    .wdata_take(wdata_take), .rsp_valid(rsp_valid), .rsp_last(rsp_last), .rsp_data(rsp_data),
    .fault(fault), .fault_kind(fault_kind), .core_reset(core_reset),
    .bus_request(bus_request), .arbiter_grant(arbiter_grant),
    .bus_ownership_ack(bus_ownership_ack), .start(start), .read_not_write(read_not_write),
    .text_not_data(text_not_data), .lock(lock), .remaining_word_count(remaining_word_count),
    .address(address), .byte_lane_enable(byte_lane_enable), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .transfer_acknowledge(transfer_acknowledge),
    .bus_error_input(bus_error_input), .retry(retry), .hard_system_reset(hard_system_reset));
  bus_slave_model slave_u (.mclk(mclk), .bus_request(bus_request), .start(start),
    .address(address), .remaining_word_count(remaining_word_count),
    .byte_lane_enable(byte_lane_enable), .data_out(data_out),
    .hard_system_reset(hard_system_reset), .arbiter_grant(arbiter_grant),
    .transfer_acknowledge(transfer_acknowledge), .bus_error_input(bus_error_input),
    .retry(retry), .data_in(data_in));
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    if (wdata_take === 1'b1)
      wnum++;
    cycles++;
    // Whole run needs well under this many cycles
    if (cycles == 20000)
    begin
      err_total++;
      $display("Error at %0t: run hung", $time);
      test_done();
    end
  end
  always @(negedge mclk)
    wdata <= 32'hC0DE_0000 + wnum;
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: word %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic test_done;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done
  task automatic wait_bit(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 100)
    begin
      @(negedge mclk);
      n++;
    end
    chk_bit(s, v);
  endtask : wait_bit
  task automatic issue(input logic w, input logic t, input logic lk, input logic [1:0] sz,
    input logic [29:0] a, input logic [3:0] be);
    req_write = w;
    req_text = t;
    req_lock = lk;
    req_size = sz;
    req_addr = a;
    req_be = be;
    req_valid = 1'b1;
    wait_bit(req_ready, 1'b1);
    @(negedge mclk);
    req_valid = 1'b0;
  endtask : issue
  task automatic get_word(input logic [29:0] a, input logic last);
    wait_bit(rsp_valid, 1'b1);
    chk_word(rsp_data, {2'h0, a} ^ 32'h5A00_0000);
    chk_bit(rsp_last, last);
    @(negedge mclk);
  endtask : get_word
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic s_single;
    issue(1'b0, 1'b0, 1'b0, 2'h0, 30'h104, 4'hF);
    get_word(30'h104, 1'b1);
    chk_bit(data_oe_n, 1'b0);
    chk_word(data_out, 32'h5A00_0104);
    chk_bit(bus_ownership_ack, 1'b1);
  endtask : s_single
  task automatic s_block;
    int i;
    slave_u.delay = 4;
    slave_u.log_addr.delete();
    slave_u.log_cnt.delete();
    issue(1'b0, 1'b0, 1'b0, 2'h2, 30'h202, 4'h1);
    for (i = 0; i < 4; i++)
    begin
      get_word({28'h80, 2'(i + 2)}, i == 3);
      chk_word({2'h0, slave_u.log_addr[i]}, {2'h0, 28'h80, 2'(i + 2)});
      chk_word({30'h0, slave_u.log_cnt[i]}, 32'(3 - i));
    end
    slave_u.delay = 1;
    issue(1'b0, 1'b1, 1'b0, 2'h0, 30'h40, 4'hF);
    get_word(30'h40, 1'b0);
    get_word(30'h41, 1'b1);
    chk_bit(text_not_data, 1'b1);
  endtask : s_block
  task automatic s_write;
    int i;
    int w0;
    w0 = wnum;
    slave_u.log_be.delete();
    slave_u.log_data.delete();
    issue(1'b1, 1'b0, 1'b0, 2'h0, 30'h80, 4'h3);
    wait_bit(req_ready, 1'b1);
    issue(1'b1, 1'b0, 1'b0, 2'h1, 30'h85, 4'hF);
    wait_bit(req_ready, 1'b1);
    chk_word({28'h0, slave_u.log_be[0]}, 32'h3);
    for (i = 0; i < 3; i++)
      chk_word(slave_u.log_data[i], 32'hC0DE_0000 + w0 + i);
    chk_word({2'h0, address}, 32'h86);
    chk_bit(read_not_write, 1'b0);
  endtask : s_write
  task automatic s_rmw;
    issue(1'b0, 1'b0, 1'b1, 2'h0, 30'h300, 4'hF);
    get_word(30'h300, 1'b1);
    chk_bit(lock, 1'b1);
    issue(1'b1, 1'b0, 1'b1, 2'h0, 30'h300, 4'hF);
    slave_u.grant_en = 1'b0;
    wait_bit(lock, 1'b0);
    chk_bit(bus_ownership_ack, 1'b1);
    wait_bit(bus_ownership_ack, 1'b0);
    chk_bit(bus_request, 1'b0);
    slave_u.grant_en = 1'b1;
  endtask : s_rmw
  task automatic s_retry;
    int n0;
    n0 = slave_u.starts;
    slave_u.log_addr.delete();
    slave_u.retry_arm = 1'b1;
    issue(1'b0, 1'b0, 1'b0, 2'h1, 30'h500, 4'hF);
    get_word(30'h500, 1'b0);
    get_word(30'h501, 1'b1);
    chk_word(32'(slave_u.starts - n0), 32'h3);
    chk_word({2'h0, slave_u.log_addr[1]}, 32'h501);
  endtask : s_retry
  task automatic s_fail;
    slave_u.bus_error_input_arm = 1'b1;
    issue(1'b1, 1'b0, 1'b0, 2'h0, 30'h600, 4'hF);
    wait_bit(fault, 1'b1);
    chk_word({29'h0, fault_kind}, 32'h1);
    slave_u.delay = 30;
    issue(1'b0, 1'b0, 1'b0, 2'h0, 30'h700, 4'hF);
    repeat (4) @(negedge mclk);
    hard_system_reset = 1'b1;
    wait_bit(core_reset, 1'b1);
    chk_bit(bus_ownership_ack, 1'b0);
    chk_bit(req_ready, 1'b0);
    repeat (30) @(negedge mclk);
    hard_system_reset = 1'b0;
    slave_u.delay = 1;
    s_single();
  endtask : s_fail
  initial
  begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_text = 1'b0;
    req_lock = 1'b0;
    req_size = 2'h0;
    req_addr = 30'h0;
    req_be = 4'h0;
    wdata = 32'h0;
    hard_system_reset = 1'b0;
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    chk_bit(read_not_write, 1'b1);
    chk_bit(data_oe_n, 1'b1);
    s_single();
    s_block();
    s_write();
    s_rmw();
    s_retry();
    s_fail();
    test_done();
  end
endmodule : processor_bus_transaction_unit_bench
bind processor_bus_transaction_unit ptu_checker chk_u (.mclk(mclk), .rst(rst), .start(start),
  .bus_ownership_ack(bus_ownership_ack), .lock(lock), .read_not_write(read_not_write),
  .text_not_data(text_not_data), .remaining_word_count(remaining_word_count),
  .byte_lane_enable(byte_lane_enable), .data_out(data_out), .data_oe_n(data_oe_n),
  .rsp_data(rsp_data), .rsp_valid(rsp_valid), .rsp_last(rsp_last), .fault(fault),
  .core_reset(core_reset), .transfer_acknowledge(transfer_acknowledge),
  .bus_error_input(bus_error_input), .retry(retry), .hard_system_reset(hard_system_reset));
`default_nettype wire
